// File: core/fuse_system_config_decode.sv
// Design decision made here: the address-and-strobe port.
module fuse_system_config_decode #(
  parameter int          FLASH_BLOCKS  = 192,
  parameter logic [31:0] CYCLES_PER_MS = 32'(fuse_cfg_pkg::CYCLES_PER_MS)
) (
  input  wire logic                      clk_i,
  input  wire logic                      reset_n_i,
  input  wire fuse_cfg_pkg::fuse_bytes_s fuse_i,
  input  wire logic                      fuse_valid_i,
  input  wire logic                      device_locked_i,
  input  wire logic                      chip_erase_i,
  input  wire logic                      check_done_i,
  input  wire logic                      check_ok_i,
  input  wire logic [3:0]                reg_addr_i,
  input  wire logic [7:0]                reg_wdata_i,
  input  wire logic                      reg_we_i,
  input  wire logic                      reg_re_i,
  input  wire logic [15:0]               fetch_addr_i,
  output logic [7:0]                     reg_rdata_o,
  output fuse_cfg_pkg::section_e         fetch_section_o,
  output logic [8:0]                     boot_limit_o,
  output logic [8:0]                     app_limit_o,
  output logic                           reset_pin_is_reset_o,
  output logic                           eeprom_erase_o,
  output logic                           flash_erase_o,
  output logic                           check_start_o,
  output logic [8:0]                     check_blocks_o,
  output logic                           config_valid_o,
  output logic                           cpu_run_o
);

  // Flash size in 256-byte blocks
  localparam logic [8:0] TOP = 9'(FLASH_BLOCKS);

  // End bytes past the top of flash are held to the top
  function automatic logic [8:0] clamp_top(input logic [8:0] lim);
    clamp_top = (lim > TOP) ? TOP : lim;
  endfunction

  // App end at or below boot end leaves no code section; boot alone is checked
  function automatic logic [8:0] code_top(input logic [8:0] boot, input logic [8:0] app);
    code_top = (app > boot) ? app : boot;
  endfunction

  // Start-up order: load, wait, check, then run or halt
  typedef enum logic [2:0] {
    ST_LOAD,
    ST_DELAY,
    ST_CHECK_REQ,
    ST_CHECK_WAIT,
    ST_RUN,
    ST_HALT
  } state_e;

  // Latched fuse image
  fuse_cfg_pkg::fuse_bytes_s fuse;
  fuse_cfg_pkg::fuse_bytes_s next_fuse;
  logic                      loaded;
  logic                      next_loaded;
  logic [8:0]                boot_lim;
  logic [8:0]                next_boot_lim;
  logic [8:0]                app_lim;
  logic [8:0]                next_app_lim;
  logic                      rst_pin;
  logic                      next_rst_pin;

  // Values worked out for the load edge
  logic [8:0]                load_boot_lim;
  logic [8:0]                load_app_lim;
  logic [31:0]               load_wait;

  // Start-up sequence
  state_e                    state;
  state_e                    next_state;
  logic [31:0]               wait_cnt;
  logic [31:0]               next_wait_cnt;
  logic                      start;
  logic                      next_start;
  logic [8:0]                check_blocks;
  logic [8:0]                next_check_blocks;
  logic                      check_fail;
  logic                      next_check_fail;
  logic                      check_done;
  logic                      next_check_done;
  logic                      run;
  logic                      next_run;

  // Erase handling
  logic                      ee_erase;
  logic                      next_ee_erase;
  logic                      fl_erase;
  logic                      next_fl_erase;

  // Register port
  logic [7:0]                rdata;
  logic [7:0]                next_rdata;
  logic                      wr_seen;
  logic                      next_wr_seen;

  fuse_cfg_pkg::region_e     region;
  logic [2:0]                delay_code;
  logic                      ee_keep;
  logic [7:0]                status;

  // Region code decides the check span
  assign region     = fuse_cfg_pkg::region_e'(fuse.system_config_byte_zero[fuse_cfg_pkg::REGION_LSB +: 2]);
  assign delay_code = fuse.system_config_byte_one[fuse_cfg_pkg::DELAY_LSB +: 3];
  assign ee_keep    = fuse.system_config_byte_zero[fuse_cfg_pkg::EE_KEEP_BIT];

  // Taken from the incoming bytes so the image and limits land on one edge
  assign load_boot_lim = clamp_top(fuse_cfg_pkg::boot_limit(fuse_i.boot_end_field, TOP));
  assign load_app_lim  = clamp_top(fuse_cfg_pkg::app_limit(fuse_i.boot_end_field,
                                                           fuse_i.app_code_end_field, TOP));
  assign load_wait     = fuse_cfg_pkg::delay_cycles(
                           fuse_i.system_config_byte_one[fuse_cfg_pkg::DELAY_LSB +: 3], CYCLES_PER_MS);

  // Fuse image group
  always_comb begin
    next_fuse     = fuse;
    next_loaded   = loaded;
    next_boot_lim = boot_lim;
    next_app_lim  = app_lim;
    next_rst_pin  = rst_pin;
    // Captured once; later changes of the source are ignored
    if (state == ST_LOAD && fuse_valid_i) begin
      next_fuse     = fuse_i;
      next_loaded   = 1'b1;
      next_boot_lim = load_boot_lim;
      next_app_lim  = load_app_lim;
      next_rst_pin  = fuse_i.system_config_byte_zero[fuse_cfg_pkg::RST_PIN_BIT];
    end
  end

  // Reset clears the image only; programmed defaults come from the source
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      fuse     <= '0;
      loaded   <= 1'b0;
      boot_lim <= '0;
      app_lim  <= '0;
      rst_pin  <= 1'b0;
    end else begin
      fuse     <= next_fuse;
      loaded   <= next_loaded;
      boot_lim <= next_boot_lim;
      app_lim  <= next_app_lim;
      rst_pin  <= next_rst_pin;
    end
  end

  // Start-up sequence group
  always_comb begin
    next_state        = state;
    next_wait_cnt     = wait_cnt;
    next_start        = 1'b0;
    next_check_blocks = check_blocks;
    next_check_fail   = check_fail;
    next_check_done   = check_done;
    case (state)
      ST_LOAD: begin
        if (fuse_valid_i) begin
          next_wait_cnt = load_wait;
          next_state    = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (wait_cnt == 32'h0) begin
          next_state = ST_CHECK_REQ;
        end else begin
          next_wait_cnt = wait_cnt - 32'h1;
        end
      end
      ST_CHECK_REQ: begin
        case (region)
          fuse_cfg_pkg::REGION_FLASH: begin
            next_check_blocks = TOP;
            next_start        = 1'b1;
            next_state        = ST_CHECK_WAIT;
          end
          fuse_cfg_pkg::REGION_BOOT: begin
            next_check_blocks = boot_lim;
            next_start        = 1'b1;
            next_state        = ST_CHECK_WAIT;
          end
          fuse_cfg_pkg::REGION_BOOT_AND_APP: begin
            next_check_blocks = code_top(boot_lim, app_lim);
            next_start        = 1'b1;
            next_state        = ST_CHECK_WAIT;
          end
          default: begin
            next_check_blocks = 9'h0;
            next_state        = ST_RUN;
          end
        endcase
      end
      ST_CHECK_WAIT: begin
        // Execution waits until the checker answers
        if (check_done_i) begin
          next_check_done = 1'b1;
          next_check_fail = !check_ok_i;
          next_state      = check_ok_i ? ST_RUN : ST_HALT;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      ST_HALT: begin
        // Bad image never runs; only a new reset leaves
        next_state = ST_HALT;
      end
      default: begin
        next_state = ST_LOAD;
      end
    endcase
    // Registered so the run level comes straight from a flop
    next_run = (next_state == ST_RUN);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state        <= ST_LOAD;
      wait_cnt     <= '0;
      start        <= 1'b0;
      check_blocks <= '0;
      check_fail   <= 1'b0;
      check_done   <= 1'b0;
      run          <= 1'b0;
    end else begin
      state        <= next_state;
      wait_cnt     <= next_wait_cnt;
      start        <= next_start;
      check_blocks <= next_check_blocks;
      check_fail   <= next_check_fail;
      check_done   <= next_check_done;
      run          <= next_run;
    end
  end

  // Erase group
  always_comb begin
    next_ee_erase = 1'b0;
    next_fl_erase = 1'b0;
    // Before the image is loaded the keep bit is unknown, so erase is held off
    if (chip_erase_i && loaded) begin
      next_fl_erase = 1'b1;
      // Lock is taken live, so a lock set after load still wins
      if (device_locked_i) begin
        next_ee_erase = 1'b1;
      end else begin
        next_ee_erase = !ee_keep;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ee_erase <= 1'b0;
      fl_erase <= 1'b0;
    end else begin
      ee_erase <= next_ee_erase;
      fl_erase <= next_fl_erase;
    end
  end

  // Register port group
  always_comb begin
    status = 8'h0;
    // Lock bit follows the pin, unlike the latched image
    status[fuse_cfg_pkg::ST_RUN_BIT]  = run;
    status[fuse_cfg_pkg::ST_DONE_BIT] = check_done;
    status[fuse_cfg_pkg::ST_FAIL_BIT] = check_fail;
    status[fuse_cfg_pkg::ST_LOCK_BIT] = device_locked_i;
    status[fuse_cfg_pkg::ST_WR_BIT]   = wr_seen;
  end

  always_comb begin
    next_rdata   = 8'h0;
    next_wr_seen = wr_seen;
    if (reg_re_i) begin
      case (reg_addr_i)
        fuse_cfg_pkg::OFS_SYS_CFG0: next_rdata = fuse.system_config_byte_zero;
        fuse_cfg_pkg::OFS_STARTUP:  next_rdata = {5'h0, delay_code};
        fuse_cfg_pkg::OFS_APP_END:  next_rdata = fuse.app_code_end_field;
        fuse_cfg_pkg::OFS_BOOT_END: next_rdata = fuse.boot_end_field;
        fuse_cfg_pkg::OFS_STATUS: begin
          next_rdata   = status;
          next_wr_seen = 1'b0;
        end
        default: next_rdata = 8'h0;
      endcase
    end
    // Writes never reach the image; a new write beats the read clear
    if (reg_we_i) begin
      next_wr_seen = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata   <= 8'h0;
      wr_seen <= 1'b0;
    end else begin
      rdata   <= next_rdata;
      wr_seen <= next_wr_seen;
    end
  end

  fuse_section_map u_section_map (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .block_i    (fetch_addr_i[15:8]),
    .boot_lim_i (boot_lim),
    .app_lim_i  (app_lim),
    .section_o  (fetch_section_o)
  );

  assign reg_rdata_o          = rdata;
  assign boot_limit_o         = boot_lim;
  assign app_limit_o          = app_lim;
  assign reset_pin_is_reset_o = rst_pin;
  assign eeprom_erase_o       = ee_erase;
  assign flash_erase_o        = fl_erase;
  assign check_start_o        = start;
  assign check_blocks_o       = check_blocks;
  assign config_valid_o       = loaded;
  assign cpu_run_o            = run;

endmodule // fuse_system_config_decode

// File: pkg/fuse_cfg_pkg.sv
package fuse_cfg_pkg;

  // Register offsets, one byte each
  localparam logic [3:0] OFS_SYS_CFG0     = 4'h5;
  localparam logic [3:0] OFS_STARTUP      = 4'h6;
  localparam logic [3:0] OFS_APP_END      = 4'h7;
  localparam logic [3:0] OFS_BOOT_END     = 4'h8;
  localparam logic [3:0] OFS_STATUS       = 4'hf;

  // Field positions in system_config_byte_zero
  localparam int REGION_LSB   = 6;
  localparam int RST_PIN_BIT  = 3;
  localparam int EE_KEEP_BIT  = 0;
  // Field position in system_config_byte_one
  localparam int DELAY_LSB    = 0;

  // Status register bits
  localparam int ST_RUN_BIT   = 0;
  localparam int ST_DONE_BIT  = 1;
  localparam int ST_FAIL_BIT  = 2;
  localparam int ST_LOCK_BIT  = 3;
  localparam int ST_WR_BIT    = 4;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int BLOCK_BYTES  = 256;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS         = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    REGION_FLASH,
    REGION_BOOT,
    REGION_BOOT_AND_APP,
    REGION_NONE
  } region_e;

  typedef enum logic [1:0] {
    SECT_BOOT,
    SECT_APP_CODE,
    SECT_APP_DATA
  } section_e;

  typedef struct packed {
    logic [7:0] system_config_byte_zero;
    logic [7:0] system_config_byte_one;
    logic [7:0] app_code_end_field;
    logic [7:0] boot_end_field;
  } fuse_bytes_s;

  // Boot boundary in blocks; zero means whole flash
  function automatic logic [8:0] boot_limit(input logic [7:0] boot_end, input logic [8:0] top);
    boot_limit = (boot_end == BYTE_ZERO) ? top : {1'b0, boot_end};
  endfunction

  // App code boundary in blocks
  function automatic logic [8:0] app_limit(input logic [7:0] boot_end, input logic [7:0] app_end,
                                           input logic [8:0] top);
    if (boot_end == BYTE_ZERO || app_end == BYTE_ZERO) begin
      app_limit = top;
    end else begin
      app_limit = {1'b0, app_end};
    end
  endfunction

  // Powers of two from one ms, code zero gives no wait
  function automatic logic [31:0] delay_cycles(input logic [2:0] code, input logic [31:0] per_ms);
    delay_cycles = (code == 3'h0) ? 32'h0 : (per_ms << (code - 3'h1));
  endfunction

endpackage

// File: core/fuse_section_map.sv
module fuse_section_map (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [7:0]            block_i,
  input  wire logic [8:0]            boot_lim_i,
  input  wire logic [8:0]            app_lim_i,
  output fuse_cfg_pkg::section_e     section_o
);

  fuse_cfg_pkg::section_e section;
  fuse_cfg_pkg::section_e next_section;

  always_comb begin
    if ({1'b0, block_i} < boot_lim_i) begin
      next_section = fuse_cfg_pkg::SECT_BOOT;
    end else if ({1'b0, block_i} < app_lim_i) begin
      next_section = fuse_cfg_pkg::SECT_APP_CODE;
    end else begin
      next_section = fuse_cfg_pkg::SECT_APP_DATA;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      section <= fuse_cfg_pkg::SECT_BOOT;
    end else begin
      section <= next_section;
    end
  end

  assign section_o = section;

endmodule // fuse_section_map

// File: testbench/fuse_cfg_checker_assertions.sv
module fuse_cfg_checker #(
  parameter int FLASH_BLOCKS = 192
) (
  input wire logic                      clk_i,
  input wire logic                      reset_n_i,
  input wire fuse_cfg_pkg::fuse_bytes_s fuse_i,
  input wire logic                      device_locked_i,
  input wire logic                      chip_erase_i,
  input wire logic                      check_done_i,
  input wire logic                      check_ok_i,
  input wire logic                      reg_re_i,
  input wire logic [15:0]               fetch_addr_i,
  input wire logic [7:0]                reg_rdata_o,
  input wire fuse_cfg_pkg::section_e    fetch_section_o,
  input wire logic [8:0]                boot_limit_o,
  input wire logic [8:0]                app_limit_o,
  input wire logic                      reset_pin_is_reset_o,
  input wire logic                      eeprom_erase_o,
  input wire logic                      flash_erase_o,
  input wire logic                      check_start_o,
  input wire logic [8:0]                check_blocks_o,
  input wire logic                      config_valid_o,
  input wire logic                      cpu_run_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Bench holds the fuse bytes steady outside reset, so they stand for the latched image
  logic [1:0] region;
  assign region = fuse_i.system_config_byte_zero[7:6];

  rdata_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
    else $error("read data seen without a read");
  erase_kind_a: assert property (chip_erase_i && config_valid_o |=> flash_erase_o &&
    eeprom_erase_o == ($past(device_locked_i) || !$past(fuse_i.system_config_byte_zero[0])))
    else $error("erase outputs wrong");
  erase_quiet_a: assert property (!chip_erase_i |=> !flash_erase_o && !eeprom_erase_o)
    else $error("erase without request");
  limits_hold_a: assert property (config_valid_o && $past(config_valid_o) |->
    $stable(boot_limit_o) && $stable(app_limit_o)) else $error("limits moved while running");
  start_once_a: assert property (check_start_o |=> !check_start_o [*8])
    else $error("check start repeated");
  no_check_a: assert property (check_start_o |-> region != 2'h3)
    else $error("check started with check disabled");
  check_span_a: assert property (check_start_o |-> check_blocks_o ==
    (region == 2'h0 ? 9'(FLASH_BLOCKS) : region == 2'h1 ? boot_limit_o :
     app_limit_o > boot_limit_o ? app_limit_o : boot_limit_o))
    else $error("check span wrong");
  run_hold_a: assert property (cpu_run_o |=> cpu_run_o)
    else $error("run dropped");
  run_cause_a: assert property ($rose(cpu_run_o) |-> config_valid_o &&
    (($past(check_done_i) && $past(check_ok_i)) || region == 2'h3)) else $error("run without good check");
  pin_mode_a: assert property (config_valid_o |->
    reset_pin_is_reset_o == fuse_i.system_config_byte_zero[3]) else $error("pin mode wrong");
  fetch_section_a: assert property (config_valid_o && $past(config_valid_o) |-> fetch_section_o ==
    ({1'b0, $past(fetch_addr_i[15:8])} < $past(boot_limit_o) ? fuse_cfg_pkg::SECT_BOOT :
     {1'b0, $past(fetch_addr_i[15:8])} < $past(app_limit_o) ? fuse_cfg_pkg::SECT_APP_CODE :
     fuse_cfg_pkg::SECT_APP_DATA)) else $error("section wrong");

  cover property (check_start_o);
  cover property ($rose(cpu_run_o));
  cover property (flash_erase_o && !eeprom_erase_o);
endmodule // fuse_cfg_checker

bind fuse_system_config_decode fuse_cfg_checker #(.FLASH_BLOCKS(FLASH_BLOCKS)) u_chk (
  .clk_i, .reset_n_i, .fuse_i, .device_locked_i, .chip_erase_i, .check_done_i, .check_ok_i, .reg_re_i,
  .fetch_addr_i, .reg_rdata_o, .fetch_section_o, .boot_limit_o, .app_limit_o, .reset_pin_is_reset_o,
  .eeprom_erase_o, .flash_erase_o, .check_start_o, .check_blocks_o, .config_valid_o, .cpu_run_o);

// File: testbench/tb_fuse_system_config_decode.sv
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module tb_fuse_system_config_decode;
  timeunit 1ns;
  timeprecision 1ns;
  // Short ms keeps the 64 ms code to a few hundred cycles
  localparam int CPM = 4;
  localparam int FB  = 192;
  logic                      clk_i, reset_n_i, fuse_valid_i, device_locked_i, chip_erase_i;
  logic                      check_done_i, check_ok_i, reg_we_i, reg_re_i;
  fuse_cfg_pkg::fuse_bytes_s fuse_i;
  logic [3:0]                reg_addr_i;
  logic [7:0]                reg_wdata_i, reg_rdata_o;
  logic [15:0]               fetch_addr_i;
  fuse_cfg_pkg::section_e    fetch_section_o;
  logic [8:0]                boot_limit_o, app_limit_o, check_blocks_o;
  logic                      reset_pin_is_reset_o, eeprom_erase_o, flash_erase_o;
  logic                      check_start_o, config_valid_o, cpu_run_o;
  int                        err_total, cmp_count, cyc;

  fuse_system_config_decode #(.FLASH_BLOCKS(FB), .CYCLES_PER_MS(32'(CPM))) u_dut (
    .clk_i, .reset_n_i, .fuse_i, .fuse_valid_i, .device_locked_i, .chip_erase_i, .check_done_i,
    .check_ok_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .fetch_addr_i, .reg_rdata_o,
    .fetch_section_o, .boot_limit_o, .app_limit_o, .reset_pin_is_reset_o, .eeprom_erase_o,
    .flash_erase_o, .check_start_o, .check_blocks_o, .config_valid_o, .cpu_run_o);

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i); reg_addr_i <= a; reg_re_i <= 1'b1;
    @(posedge clk_i); reg_re_i <= 1'b0; #1;
    `CHK("reg_rdata_o", e, reg_rdata_o)
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i); reg_addr_i <= a; reg_wdata_i <= d; reg_we_i <= 1'b1;
    @(posedge clk_i); reg_we_i <= 1'b0;
  endtask

  task automatic sect(input logic [15:0] a, input fuse_cfg_pkg::section_e e);
    @(posedge clk_i); fetch_addr_i <= a;
    @(posedge clk_i); #1;
    `CHK("fetch_section_o", e, fetch_section_o)
  endtask

  task automatic erase(input logic l, input logic e);
    @(posedge clk_i); chip_erase_i <= 1'b1; device_locked_i <= l;
    @(posedge clk_i); chip_erase_i <= 1'b0; #1;
    `CHK("flash_erase_o", 1'b1, flash_erase_o)
    `CHK("eeprom_erase_o", e, eeprom_erase_o)
  endtask

  task automatic done(input logic ok);
    @(posedge clk_i); check_done_i <= 1'b1; check_ok_i <= ok;
    @(posedge clk_i); check_done_i <= 1'b0; #1;
    `CHK("cpu_run_o", ok, cpu_run_o)
  endtask

  task automatic boot_run(input logic [7:0] c0, c1, ae, be, input logic [8:0] eb, ea, blk);
    int n;
    int w;
    w = (c1[2:0] == 3'h0) ? 2 : (CPM << (c1[2:0] - 3'h1)) + 2;
    @(posedge clk_i); reset_n_i <= 1'b0; fuse_valid_i <= 1'b0; device_locked_i <= 1'b0;
    fuse_i <= {c0, c1, ae, be};
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1; fuse_valid_i <= 1'b1;
    n = 0;
    do begin @(posedge clk_i); #1; n++; end while (config_valid_o !== 1'b1 && n < 10);
    n = 0;
    while (check_start_o !== 1'b1 && cpu_run_o !== 1'b1 && n < 400) begin @(posedge clk_i); #1; n++; end
    `CHK("startup_wait", w, n)
    `CHK("check_start_o", c0[7:6] != 2'h3, check_start_o)
    `CHK("check_blocks_o", blk, check_blocks_o)
    `CHK("boot_limit_o", eb, boot_limit_o)
    `CHK("app_limit_o", ea, app_limit_o)
    `CHK("reset_pin_is_reset_o", c0[3], reset_pin_is_reset_o)
    rd(4'h5, c0);
    rd(4'h6, {5'h00, c1[2:0]});
    rd(4'h7, ae);
    rd(4'h8, be);
  endtask

  task automatic t_split_flash;
    boot_run(8'h89, 8'h03, 8'h20, 8'h10, 9'd16, 9'd32, 9'd32);
    wr(4'h7, 8'hff);
    rd(4'h7, 8'h20);
    rd(4'h3, 8'h00);
    done(1'b1);
    rd(4'hf, 8'h13);
    rd(4'hf, 8'h03);
    sect(16'h0fff, fuse_cfg_pkg::SECT_BOOT);
    sect(16'h1000, fuse_cfg_pkg::SECT_APP_CODE);
    sect(16'h1fff, fuse_cfg_pkg::SECT_APP_CODE);
    sect(16'h2000, fuse_cfg_pkg::SECT_APP_DATA);
    erase(1'b0, 1'b0);
    erase(1'b1, 1'b1);
    $display("split flash test done");
  endtask

  task automatic t_whole_boot;
    boot_run(8'h00, 8'h07, 8'h20, 8'h00, 9'd192, 9'd192, 9'd192);
    sect(16'h2fff, fuse_cfg_pkg::SECT_BOOT);
    erase(1'b0, 1'b1);
    done(1'b0);
    rd(4'hf, 8'h06);
    $display("whole boot test done");
  endtask

  task automatic t_boot_only;
    boot_run(8'h41, 8'h01, 8'h00, 8'h10, 9'd16, 9'd192, 9'd16);
    sect(16'hbfff, fuse_cfg_pkg::SECT_APP_CODE);
    erase(1'b0, 1'b0);
    $display("boot only test done");
  endtask

  task automatic t_no_check;
    boot_run(8'hc8, 8'h00, 8'h30, 8'h08, 9'd8, 9'd48, 9'd0);
    `CHK("cpu_run_o", 1'b1, cpu_run_o)
    sect(16'h3000, fuse_cfg_pkg::SECT_APP_DATA);
    $display("no check test done");
  endtask

  task automatic t_no_code;
    boot_run(8'h80, 8'h00, 8'h08, 8'hf0, 9'd192, 9'd8, 9'd192);
    sect(16'h0800, fuse_cfg_pkg::SECT_BOOT);
    $display("no code section test done");
  endtask

  initial begin
    reset_n_i = 1'b0; fuse_valid_i = 1'b0; device_locked_i = 1'b0; chip_erase_i = 1'b0;
    check_done_i = 1'b0; check_ok_i = 1'b0; reg_we_i = 1'b0; reg_re_i = 1'b0;
    fuse_i = '0; reg_addr_i = 4'h0; reg_wdata_i = 8'h00; fetch_addr_i = 16'h0000;
    err_total = 0; cmp_count = 0; cyc = 0;
    t_split_flash();
    t_whole_boot();
    t_boot_only();
    t_no_check();
    t_no_code();
    conclude();
  end
endmodule // tb_fuse_system_config_decode
